// file: rtl/trap_ctl_pkg.sv
// package: register map, field positions and reset values of the trap and nesting control block
package trap_ctl_pkg;
  // register byte offsets (32-bit aligned words)
  localparam logic [3:0]  TRAP_CTL_OFF   = 4'h0;
  localparam logic [3:0]  IRQ_STATUS_OFF = 4'h4;
  localparam logic [3:0]  IRQ_MASK_OFF   = 4'h8;
  localparam logic [3:0]  PRIO_OFF       = 4'hC;
  // field positions of trap_and_nesting_control
  localparam int NEST_DIS_BIT  = 15;
  localparam int OVA_FLAG_BIT  = 14;
  localparam int OVB_FLAG_BIT  = 13;
  localparam int COVA_FLAG_BIT = 12;
  localparam int COVB_FLAG_BIT = 11;
  localparam int OVA_EN_BIT    = 10;
  localparam int OVB_EN_BIT    = 9;
  localparam int COV_EN_BIT    = 8;
  localparam int SHIFT_BIT     = 7;
  localparam int DIV0_BIT      = 6;
  localparam int DMA_BIT       = 5;
  localparam int MATH_BIT      = 4;
  localparam int ADDR_BIT      = 3;
  localparam int STACK_BIT     = 2;
  localparam int OSC_BIT       = 1;
  // sticky flag bits and control bits of the register
  localparam logic [15:0] FLAG_MASK      = 16'h78FE;
  localparam logic [15:0] CTRL_MASK      = 16'h8700;
  localparam logic [15:0] TRAP_CTL_RESET = 16'h0000;
  localparam logic [15:0] IRQ_RESET      = 16'h0000;
  localparam logic [2:0]  PRIO_RESET     = 3'h0;
  // interrupt event count (width of status and mask registers)
  localparam int NUM_EVENTS = 9;
endpackage

// file: rtl/trap_event_sync.sv
// two-flop synchroniser and rising-edge pulse for asynchronous trap inputs
`timescale 1ns/1ps
module trap_event_sync
  import trap_ctl_pkg::*;
#(
  parameter int WIDTH = 9
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // raw level and resulting edge pulse
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // two flops, then a delayed copy for edge detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else if (clk_en) begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // one-cycle pulse on each rising level
  assign rise_pulse = sync_reg & ~last_reg & {WIDTH{clk_en}};
endmodule

// file: rtl/trap_status_nesting_control.sv
// trap status and nesting control register with wishbone slave and trap interrupt
// What this block does
// - bit 15 disables interrupt nesting when set
// - bits 14/13 flag accumulator A/B overflow traps
// - bits 12/11 flag catastrophic A/B overflow traps
// - bits 10/9 enable A/B overflow traps
// - bit 8 enables catastrophic overflow trap
// - bit 7 flags invalid accumulator shift
// - bit 6 flags divide by zero
// - bit 5 flags DMA controller error trap
// - bit 4 flags any math error trap
// - bit 3 flags address error trap
// - bit 2 flags stack error trap
// - bit 1 flags oscillator failure trap
// - nesting disabled makes priority level read-only
`timescale 1ns/1ps
module trap_status_nesting_control
  import trap_ctl_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // trap sources from datapath and monitors (asynchronous levels)
  input  wire logic        acc_a_overflow,
  input  wire logic        acc_b_overflow,
  input  wire logic        acc_a_catastrophic,
  input  wire logic        acc_b_catastrophic,
  input  wire logic        bad_shift,
  input  wire logic        divide_by_zero,
  input  wire logic        dma_fault,
  input  wire logic        addr_fault,
  input  wire logic        stack_fault,
  input  wire logic        osc_fail,
  // nesting and priority level to the core
  output logic             nesting_disable,
  output logic      [2:0]  cpu_priority_level,
  // trap request and interrupt
  output logic             trap_request,
  output logic             irq
);
  localparam int EW = NUM_EVENTS;

  logic [15:0]   ctl_reg;
  logic [15:0]   ctl_next;
  logic [EW-1:0] irq_status_reg;
  logic [EW-1:0] irq_status_next;
  logic [EW-1:0] irq_mask_reg;
  logic [2:0]    prio_reg;
  logic [31:0]   rdata_reg;
  logic          ack_reg;
  logic          err_reg;

  // synchronise the ten raw trap levels; catastrophic A/B each have their own path
  logic [9:0] raw_vec;
  logic [9:0] ev;
  assign raw_vec = {acc_a_overflow, acc_b_overflow, acc_a_catastrophic, acc_b_catastrophic,
                    bad_shift, divide_by_zero, dma_fault, addr_fault, stack_fault, osc_fail};

  trap_event_sync #(
    .WIDTH (10)
  ) u_sync (
    .clock      (clock),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .raw_in     (raw_vec),
    .rise_pulse (ev)
  );

  // named event pulses
  wire ev_ova   = ev[9];
  wire ev_ovb   = ev[8];
  wire ev_cova  = ev[7];
  wire ev_covb  = ev[6];
  wire ev_shift = ev[5];
  wire ev_div0  = ev[4];
  wire ev_dma   = ev[3];
  wire ev_addr  = ev[2];
  wire ev_stack = ev[1];
  wire ev_osc   = ev[0];

  // bus decode
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  wire        hit_ctl   = wb_adr_i == TRAP_CTL_OFF;
  wire        hit_stat  = wb_adr_i == IRQ_STATUS_OFF;
  wire        hit_mask  = wb_adr_i == IRQ_MASK_OFF;
  wire        hit_prio  = wb_adr_i == PRIO_OFF;
  wire        hit_any   = hit_ctl | hit_stat | hit_mask | hit_prio;
  wire        wr_ok     = bus_req & wb_we_i & hit_any & clk_en;
  wire [15:0] wmask16   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wdata16   = wb_dat_i[15:0];
  wire        wr_ctl    = wr_ok & hit_ctl;
  wire        wr_stat   = wr_ok & hit_stat;
  wire        wr_mask   = wr_ok & hit_mask;
  wire        wr_prio   = wr_ok & hit_prio & wb_sel_i[0];

  // enabled overflow traps; disabled ones are not flagged
  wire trap_ova  = ev_ova & ctl_reg[OVA_EN_BIT];
  wire trap_ovb  = ev_ovb & ctl_reg[OVB_EN_BIT];
  wire trap_cova = ev_cova & ctl_reg[COV_EN_BIT];
  wire trap_covb = ev_covb & ctl_reg[COV_EN_BIT];
  wire trap_math = trap_ova | trap_ovb | trap_cova | trap_covb | ev_shift | ev_div0;

  // hardware set vector, aligned with the register layout
  logic [15:0] hw_set;
  always_comb begin
    hw_set                = 16'h0000;
    hw_set[OVA_FLAG_BIT]  = trap_ova;
    hw_set[OVB_FLAG_BIT]  = trap_ovb;
    hw_set[COVA_FLAG_BIT] = trap_cova;
    hw_set[COVB_FLAG_BIT] = trap_covb;
    hw_set[SHIFT_BIT]     = ev_shift;
    hw_set[DIV0_BIT]      = ev_div0;
    hw_set[DMA_BIT]       = ev_dma;
    hw_set[MATH_BIT]      = trap_math;
    hw_set[ADDR_BIT]      = ev_addr;
    hw_set[STACK_BIT]     = ev_stack;
    hw_set[OSC_BIT]       = ev_osc;
  end

  // control register next value: byte-masked write, hardware set wins over clear
  wire [15:0] ctl_written = (ctl_reg & ~wmask16) | (wdata16 & wmask16);
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) begin
      ctl_next = ctl_written & (CTRL_MASK | FLAG_MASK);
    end
    ctl_next = ctl_next | hw_set;
  end

  // interrupt events: one per status group in the low bits
  wire [EW-1:0] irq_ev = {hw_set[OSC_BIT], hw_set[STACK_BIT], hw_set[ADDR_BIT], hw_set[MATH_BIT],
                          hw_set[DMA_BIT], hw_set[DIV0_BIT], hw_set[SHIFT_BIT],
                          trap_cova | trap_covb, trap_ova | trap_ovb};
  wire [EW-1:0] w1c    = wr_stat ? (wdata16[EW-1:0] & wmask16[EW-1:0]) : '0;
  assign irq_status_next = (irq_status_reg & ~w1c) | irq_ev;

  // trap control and status registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg        <= TRAP_CTL_RESET;
      irq_status_reg <= IRQ_RESET[EW-1:0];
      irq_mask_reg   <= IRQ_RESET[EW-1:0];
    end else if (clk_en) begin
      ctl_reg        <= ctl_next;
      irq_status_reg <= irq_status_next;
      if (wr_mask) begin
        irq_mask_reg <= (irq_mask_reg & ~wmask16[EW-1:0]) | (wdata16[EW-1:0] & wmask16[EW-1:0]);
      end
    end
  end

  // cpu priority level: writable only while nesting is enabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prio_reg <= PRIO_RESET;
    end else if (clk_en && wr_prio && !ctl_reg[NEST_DIS_BIT]) begin
      prio_reg <= wb_dat_i[2:0];
    end
  end

  // read mux; control register bit 0 and upper bits read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctl) begin
      rd_mux[15:0] = ctl_reg & (CTRL_MASK | FLAG_MASK);
    end else if (hit_stat) begin
      rd_mux[EW-1:0] = irq_status_reg;
    end else if (hit_mask) begin
      rd_mux[EW-1:0] = irq_mask_reg;
    end else if (hit_prio) begin
      rd_mux[2:0] = prio_reg;
    end
  end

  // single-cycle ack, err for unmapped addresses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg   <= bus_req & hit_any;
      err_reg   <= bus_req & ~hit_any;
      rdata_reg <= (bus_req & hit_any & ~wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // outputs
  assign wb_ack_o           = ack_reg;
  assign wb_err_o           = err_reg;
  assign wb_dat_o           = rdata_reg;
  assign nesting_disable    = ctl_reg[NEST_DIS_BIT];
  assign cpu_priority_level = prio_reg;
  assign trap_request       = |(ctl_reg & FLAG_MASK);
  assign irq                = |(irq_status_reg & irq_mask_reg);
endmodule

// file: tb/trap_status_nesting_control_chk.sv
// checker: bus, trap flag and nesting relations seen at the block's ports
`timescale 1ns/1ps
module trap_status_nesting_control_chk (
  input wire logic        clock, rst_b, clk_en, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [3:0]  wb_adr_i, wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o, wb_err_o, bad_shift, divide_by_zero, dma_fault, addr_fault,
  input wire logic        stack_fault, osc_fail, nesting_disable, trap_request, irq,
  input wire logic [2:0]  cpu_priority_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // request taken at this edge, and the two writes of interest
  wire taken   = wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o;
  wire wr_ctl  = taken && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1];
  wire wr_prio = taken && wb_we_i && wb_adr_i == 4'hC && wb_sel_i[0];
  AST_NEST_BIT: assert property (wr_ctl |=> nesting_disable == $past(wb_dat_i[15]))
    else $error("nesting disable does not follow write");
  AST_PRIO_LOCK: assert property (nesting_disable |=> $stable(cpu_priority_level))
    else $error("priority level changed while nesting disabled");
  AST_PRIO_WR: assert property (wr_prio && !nesting_disable |=> cpu_priority_level == $past(wb_dat_i[2:0]))
    else $error("priority level write lost");
  AST_SHIFT: assert property ($rose(bad_shift) |-> ##[1:5] trap_request)
    else $error("shift error raised no trap");
  AST_DIV0: assert property ($rose(divide_by_zero) |-> ##[1:5] trap_request)
    else $error("divide by zero raised no trap");
  AST_DMA: assert property ($rose(dma_fault) |-> ##[1:5] trap_request)
    else $error("dma fault raised no trap");
  AST_ADDR: assert property ($rose(addr_fault) |-> ##[1:5] trap_request)
    else $error("address fault raised no trap");
  AST_STACK: assert property ($rose(stack_fault) |-> ##[1:5] trap_request)
    else $error("stack fault raised no trap");
  AST_OSC: assert property ($rose(osc_fail) |-> ##[1:5] trap_request)
    else $error("oscillator failure raised no trap");
  // main scenarios
  COV_ERR: cover property (wb_err_o);
  COV_IRQ: cover property (irq && trap_request);
  COV_LOCK: cover property (nesting_disable && wr_prio);
endmodule
bind trap_status_nesting_control trap_status_nesting_control_chk chk_i (.*);

// file: tb/trap_src_model.sv
// trap source model: each fire pulse becomes a three-cycle active-high trap level
`timescale 1ns/1ps
module trap_src_model (
  // clock and event requests
  input  wire logic       clock,
  input  wire logic [9:0] fire,
  // trap levels toward the block
  output logic      [9:0] lvl
);
  logic [9:0] s0_reg = '0, s1_reg = '0, s2_reg = '0;
  // level held long enough for a two-flop synchroniser, then dropped again
  always @(posedge clock) begin
    s0_reg <= fire;
    s1_reg <= s0_reg;
    s2_reg <= s1_reg;
  end
  assign lvl = s0_reg | s1_reg | s2_reg;
endmodule

// file: tb/trap_status_nesting_control_bench.sv
// self-checking bench for the trap status and nesting control register
`timescale 1ns/1ps
module trap_status_nesting_control_bench
  import trap_ctl_pkg::*;
;
  logic        clock = 0, rst_b = 0, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0]  wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic        wb_ack_o, wb_err_o, nesting_disable, trap_request, irq;
  logic [2:0]  cpu_priority_level;
  logic [9:0]  fire = '0, lvl;
  wire         acc_a_overflow, acc_b_overflow, acc_a_catastrophic, acc_b_catastrophic, bad_shift;
  wire         divide_by_zero, dma_fault, addr_fault, stack_fault, osc_fail;
  logic [16:0] notes[$];
  int          err_total = 0, n_checks = 0;
  // expected control flags and status bits per source
  logic [15:0] fexp[10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050, 16'h0020, 16'h0008,
                            16'h0004, 16'h0002};
  logic [8:0]  sexp[10] = '{9'h021, 9'h021, 9'h022, 9'h022, 9'h024, 9'h028, 9'h010, 9'h040, 9'h080, 9'h100};
  assign {osc_fail, stack_fault, addr_fault, dma_fault, divide_by_zero, bad_shift, acc_b_catastrophic,
          acc_a_catastrophic, acc_b_overflow, acc_a_overflow} = lvl;
  trap_status_nesting_control uut (.*);
  trap_src_model src (.clock(clock), .fire(fire), .lvl(lvl));
  initial forever #4 clock = ~clock;
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic cycle; a read notes its expected {err, data}
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [16:0] e,
                    input logic [3:0] s = 4'h3);
    int n;
    n = 0;
    if (!w) notes.push_back(e);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {16'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock);
  endtask
  // pulse the sources, then give the synchroniser time
  task automatic ev(input logic [9:0] f);
    fire <= f;
    @(posedge clock);
    fire <= '0;
    repeat (6) @(posedge clock);
  endtask
  // read answers compared against the oldest note
  always @(posedge clock)
    if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && wb_we_i === 1'b0 && notes.size() > 0) begin
      chk("read upper", {1'b0, wb_dat_o[31:16]}, 17'h0);
      chk("read data", {wb_err_o, wb_dat_o[15:0]}, notes.pop_front());
    end
  initial begin
    logic [2:0] p;
    p = 3'($urandom(2950));
    repeat (6) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    for (int a = 0; a < 16; a += 4) wb(0, 4'(a), 0, 17'h0);
    wb(0, 4'h2, 0, 17'h10000);
    for (int i = 0; i < 10; i++) begin
      wb(1, TRAP_CTL_OFF, 16'h0700, 0);
      wb(1, IRQ_STATUS_OFF, 16'h01FF, 0);
      wb(1, IRQ_MASK_OFF, 16'h01FF, 0);
      ev(10'h1 << i);
      chk("irq", {16'h0, irq}, 17'h1);
      chk("trap request", {16'h0, trap_request}, 17'h1);
      wb(0, TRAP_CTL_OFF, 0, {1'b0, 16'h0700 | fexp[i]});
      wb(0, IRQ_STATUS_OFF, 0, {8'h0, sexp[i]});
    end
    wb(1, IRQ_STATUS_OFF, 16'h01FF, 0);
    wb(1, TRAP_CTL_OFF, 16'h0000, 0);
    wb(1, IRQ_MASK_OFF, 16'h0000, 0);
    chk("trap request", {16'h0, trap_request}, 17'h0);
    ev(10'h085);
    chk("irq", {16'h0, irq}, 17'h0);
    wb(0, TRAP_CTL_OFF, 0, 17'h00008);
    wb(0, IRQ_STATUS_OFF, 0, 17'h00040);
    p = 3'($urandom_range(7, 1));
    wb(1, PRIO_OFF, {13'h0, p}, 0);
    wb(0, PRIO_OFF, 0, {14'h0, p});
    wb(1, TRAP_CTL_OFF, 16'h8000, 0);
    chk("nesting", {16'h0, nesting_disable}, 17'h1);
    wb(1, PRIO_OFF, {13'h0, ~p}, 0);
    wb(0, PRIO_OFF, 0, {14'h0, p});
    wb(0, TRAP_CTL_OFF, 0, 17'h08000);
    chk("priority level", {14'h0, cpu_priority_level}, {14'h0, p});
    // low byte only: flags written to one, bit 0 stays zero, bit 15 untouched
    wb(1, TRAP_CTL_OFF, 16'hFFFF, 0, 4'h1);
    wb(0, TRAP_CTL_OFF, 0, 17'h080FE);
    chk("trap request", {16'h0, trap_request}, 17'h1);
    // second reset in mid-run brings every register back to zero
    rst_b <= 0;
    repeat (2) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    wb(0, TRAP_CTL_OFF, 0, 17'h00000);
    wb(0, PRIO_OFF, 0, 17'h00000);
    chk("nesting", {16'h0, nesting_disable}, 17'h0);
    // an enabled overflow event while the clock enable is low is not seen
    wb(1, TRAP_CTL_OFF, 16'h0400, 0);
    clk_en <= 0;
    ev(10'h001);
    clk_en <= 1;
    wb(0, TRAP_CTL_OFF, 0, 17'h00400);
    tally_and_finish();
  end
endmodule
